// ===== hw/adcrc_ctrl.sv
// Converter rate and current source control: register access, sequencing and source routing
//
// Summary of operation
// - Rate is modulator clock over 24 times value
// - Rate writes refused while any converter active
// - Rate register resets to 45 hex
// - First result follows two full conversion periods
// - Calibration always runs at maximum rate value
// - After calibration the programmed rate returns
// - Bit 6 switches both burnout currents
// - Bit 5 enables auxiliary current correction scaling
// - Bit 4 enables primary current correction scaling
// - Bit 3 routes source two between outputs
// - Bit 2 routes source one between outputs
// - Bit 1 turns source two on
// - Bit 0 turns source one on
// - Both sources may share one output
// - Current source register at D5, resets zero
// - Mode select starts calibration, rewrites coefficients
module adcrc_ctrl
	import adcrc_pkg::*;
#(
	parameter logic [7:0] DECIMATION_ADDR = adcrc_pkg::ADCRC_DECIMATION_ADDR_DEF,
	parameter int MOD_CLK_HZ = adcrc_pkg::ADCRC_MOD_CLK_HZ
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Special function register port
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_wdata_in,
	output logic [7:0] sfr_rdata_out,
	output logic write_refused_out,
	// Converter mode
	input wire logic primary_active_in,
	input wire logic aux_active_in,
	input wire logic [2:0] converter_mode_select_in,
	// Conversion timing
	output logic [7:0] effective_rate_out,
	output logic mod_tick_out,
	output logic result_ready_out,
	output logic cal_busy_out,
	output logic coef_update_out,
	// Current sources
	output logic burnout_enable_out,
	output logic aux_current_correction_out,
	output logic primary_current_correction_out,
	output logic exc1_source_one_out,
	output logic exc1_source_two_out,
	output logic exc2_source_one_out,
	output logic exc2_source_two_out
);

	// ==========================================================
	// State
	typedef struct packed {
		adcrc_state_t state;
		logic [7:0] decimation_rate;
		logic [7:0] current_source_ctrl;
		logic [7:0] rdata;
		logic refused;
		logic [ADCRC_PHASE_W-1:0] phase;
		logic mod_tick;
		logic [1:0] periods;
		logic restart;
		logic result;
		logic coef_upd;
	} adcrc_ctrl_st_t;

	adcrc_ctrl_st_t st_reg;
	adcrc_ctrl_st_t st_next;

	adcrc_dec_if dec ();

	logic any_active;
	logic cal_request;
	logic [7:0] rate_now;
	logic [ADCRC_PHASE_W-1:0] phase_sum;

	// Modulator rate must stay below the system clock for the accumulator
	localparam logic [ADCRC_PHASE_W-1:0] PHASE_STEP = ADCRC_PHASE_W'(MOD_CLK_HZ);

	// ==========================================================
	// Decodes
	assign any_active = primary_active_in | aux_active_in;
	assign cal_request = any_active && (converter_mode_select_in >= ADCRC_MODE_CAL_FIRST);
	// Calibration forces the slowest filter; user value is kept aside
	assign rate_now = (st_reg.state == ADCRC_CAL) ? ADCRC_DECIMATION_CAL : st_reg.decimation_rate;
	assign phase_sum = st_reg.phase + PHASE_STEP;

	// ==========================================================
	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.refused = 1'b0;
		st_next.result = 1'b0;
		st_next.coef_upd = 1'b0;
		st_next.restart = 1'b0;
		st_next.mod_tick = 1'b0;

		// Modulator tick from a fractional accumulator, jitter one system clock
		if (phase_sum >= ADCRC_PHASE_WRAP) begin
			st_next.phase = phase_sum - ADCRC_PHASE_WRAP;
			st_next.mod_tick = 1'b1;
		end else begin
			st_next.phase = phase_sum;
		end

		// Register writes
		if (sfr_wr_in) begin
			if (sfr_addr_in == ADCRC_CURRENT_SOURCE_ADDR) begin
				st_next.current_source_ctrl = sfr_wdata_in & ADCRC_CURRENT_SOURCE_MASK;
			end
			if (sfr_addr_in == DECIMATION_ADDR) begin
				// Out-of-range codes are stored as written; range is software's duty
				if (any_active || st_reg.state != ADCRC_IDLE) begin
					st_next.refused = 1'b1;
				end else begin
					st_next.decimation_rate = sfr_wdata_in;
				end
			end
		end

		// Register reads, registered data
		if (sfr_rd_in) begin
			if (sfr_addr_in == ADCRC_CURRENT_SOURCE_ADDR) begin
				st_next.rdata = st_reg.current_source_ctrl;
			end else if (sfr_addr_in == DECIMATION_ADDR) begin
				st_next.rdata = rate_now;
			end else begin
				st_next.rdata = ADCRC_READ_ZERO;
			end
		end

		// Conversion sequencer
		unique case (st_reg.state)
			ADCRC_IDLE: begin
				st_next.periods = 2'd0;
				if (cal_request) begin
					st_next.state = ADCRC_CAL;
					st_next.restart = 1'b1;
				end else if (any_active) begin
					st_next.state = ADCRC_SETTLE;
					st_next.restart = 1'b1;
				end
			end
			ADCRC_SETTLE: begin
				if (!any_active) begin
					st_next.state = ADCRC_IDLE;
				end else if (cal_request) begin
					st_next.state = ADCRC_CAL;
					st_next.periods = 2'd0;
					st_next.restart = 1'b1;
				end else if (dec.period_done) begin
					// Chopped inputs need two whole periods for the first word
					if (st_reg.periods + 2'd1 >= ADCRC_SETTLE_PERIODS) begin
						st_next.state = ADCRC_RUN;
						st_next.result = 1'b1;
						st_next.periods = 2'd0;
					end else begin
						st_next.periods = st_reg.periods + 2'd1;
					end
				end
			end
			ADCRC_RUN: begin
				if (!any_active) begin
					st_next.state = ADCRC_IDLE;
				end else if (cal_request) begin
					st_next.state = ADCRC_CAL;
					st_next.periods = 2'd0;
					st_next.restart = 1'b1;
				end else if (dec.period_done) begin
					st_next.result = 1'b1;
				end
			end
			ADCRC_CAL: begin
				if (!any_active) begin
					// Aborted calibration leaves the coefficients alone
					st_next.state = ADCRC_IDLE;
				end else if (dec.period_done) begin
					if (st_reg.periods + 2'd1 >= ADCRC_SETTLE_PERIODS) begin
						st_next.state = ADCRC_IDLE;
						st_next.coef_upd = 1'b1;
						st_next.periods = 2'd0;
					end else begin
						st_next.periods = st_reg.periods + 2'd1;
					end
				end
			end
		endcase
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_reg.state <= ADCRC_IDLE;
			st_reg.decimation_rate <= ADCRC_DECIMATION_RESET;
			st_reg.current_source_ctrl <= ADCRC_CURRENT_SOURCE_RESET;
			st_reg.rdata <= ADCRC_READ_ZERO;
			st_reg.refused <= 1'b0;
			st_reg.phase <= '0;
			st_reg.mod_tick <= 1'b0;
			st_reg.periods <= 2'd0;
			st_reg.restart <= 1'b0;
			st_reg.result <= 1'b0;
			st_reg.coef_upd <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// Decimation timer; restart drops run for one cycle to clear the count
	assign dec.run = (st_reg.state != ADCRC_IDLE) && !st_reg.restart;
	assign dec.rate = rate_now;
	assign dec.mod_tick = st_reg.mod_tick;

	adcrc_dec_timer u_timer (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.dec(dec)
	);

	// ==========================================================
	// Outputs
	assign sfr_rdata_out = st_reg.rdata;
	assign write_refused_out = st_reg.refused;
	assign effective_rate_out = rate_now;
	assign mod_tick_out = st_reg.mod_tick;
	assign result_ready_out = st_reg.result;
	assign cal_busy_out = (st_reg.state == ADCRC_CAL);
	assign coef_update_out = st_reg.coef_upd;

	assign burnout_enable_out = st_reg.current_source_ctrl[ADCRC_BIT_BURNOUT];
	assign aux_current_correction_out = st_reg.current_source_ctrl[ADCRC_BIT_AUX_CORR];
	assign primary_current_correction_out = st_reg.current_source_ctrl[ADCRC_BIT_PRI_CORR];

	// Routing decoded per source, so both may land on one output
	assign exc1_source_two_out = st_reg.current_source_ctrl[ADCRC_BIT_SRC2_ON] &
		st_reg.current_source_ctrl[ADCRC_BIT_SRC2_ROUTE];
	assign exc2_source_two_out = st_reg.current_source_ctrl[ADCRC_BIT_SRC2_ON] &
		~st_reg.current_source_ctrl[ADCRC_BIT_SRC2_ROUTE];
	assign exc2_source_one_out = st_reg.current_source_ctrl[ADCRC_BIT_SRC1_ON] &
		st_reg.current_source_ctrl[ADCRC_BIT_SRC1_ROUTE];
	assign exc1_source_one_out = st_reg.current_source_ctrl[ADCRC_BIT_SRC1_ON] &
		~st_reg.current_source_ctrl[ADCRC_BIT_SRC1_ROUTE];

endmodule

// ===== hw/adcrc_pkg.sv
// Shared constants and types for the converter rate and current source control block
package adcrc_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] ADCRC_CURRENT_SOURCE_ADDR = 8'hD5;
	localparam logic [7:0] ADCRC_DECIMATION_ADDR_DEF = 8'hD4;
	localparam logic [7:0] ADCRC_CURRENT_SOURCE_RESET = 8'h00;
	localparam logic [7:0] ADCRC_DECIMATION_RESET = 8'h45;
	localparam logic [7:0] ADCRC_DECIMATION_CAL = 8'hFF;
	localparam logic [7:0] ADCRC_DECIMATION_MIN = 8'h0D;
	localparam logic [7:0] ADCRC_CURRENT_SOURCE_MASK = 8'h7F;
	localparam logic [7:0] ADCRC_READ_ZERO = 8'h00;

	// ==========================================================
	// Current source register fields
	localparam int ADCRC_BIT_BURNOUT = 6;
	localparam int ADCRC_BIT_AUX_CORR = 5;
	localparam int ADCRC_BIT_PRI_CORR = 4;
	localparam int ADCRC_BIT_SRC2_ROUTE = 3;
	localparam int ADCRC_BIT_SRC1_ROUTE = 2;
	localparam int ADCRC_BIT_SRC2_ON = 1;
	localparam int ADCRC_BIT_SRC1_ON = 0;

	// ==========================================================
	// Timing
	localparam int ADCRC_SYS_CLK_HZ = 20_000_000;
	localparam int ADCRC_MOD_CLK_HZ = 32_768;
	localparam int ADCRC_CHOP_DIV = 3;
	localparam int ADCRC_SINC_DIV = 8;
	localparam int ADCRC_PHASE_W = 25;
	localparam logic [ADCRC_PHASE_W-1:0] ADCRC_PHASE_STEP = ADCRC_PHASE_W'(ADCRC_MOD_CLK_HZ);
	localparam logic [ADCRC_PHASE_W-1:0] ADCRC_PHASE_WRAP = ADCRC_PHASE_W'(ADCRC_SYS_CLK_HZ);
	localparam int ADCRC_COUNT_W = 13;
	localparam logic [ADCRC_COUNT_W-1:0] ADCRC_TICKS_PER_STEP =
		ADCRC_COUNT_W'(ADCRC_CHOP_DIV * ADCRC_SINC_DIV);
	localparam logic [1:0] ADCRC_SETTLE_PERIODS = 2'd2;

	// ==========================================================
	// Converter mode select codes; calibration occupies the upper half
	localparam logic [2:0] ADCRC_MODE_CAL_FIRST = 3'h4;

	// ==========================================================
	// Sequencer states, Gray along idle-settle-run-cal
	typedef enum logic [1:0] {
		ADCRC_IDLE = 2'h0,
		ADCRC_SETTLE = 2'h1,
		ADCRC_RUN = 2'h3,
		ADCRC_CAL = 2'h2
	} adcrc_state_t;

endpackage

// ===== hw/adcrc_dec_if.sv
// Link between the control sequencer and the decimation period timer
interface adcrc_dec_if;
	logic run;
	logic [7:0] rate;
	logic mod_tick;
	logic period_done;

	modport ctrl (
		output run,
		output rate,
		output mod_tick,
		input period_done
	);

	modport timer (
		input run,
		input rate,
		input mod_tick,
		output period_done
	);
endinterface

// ===== hw/adcrc_dec_timer.sv
// Decimation period timer counting modulator ticks per output word
module adcrc_dec_timer
	import adcrc_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Sequencer link
	adcrc_dec_if.timer dec
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [ADCRC_COUNT_W-1:0] count;
		logic done;
	} adcrc_timer_st_t;

	adcrc_timer_st_t st_reg;
	adcrc_timer_st_t st_next;
	logic [ADCRC_COUNT_W-1:0] limit;

	// Three chop phases of eight modulator ticks per step
	assign limit = ADCRC_COUNT_W'(dec.rate) * ADCRC_TICKS_PER_STEP;

	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		if (!dec.run) begin
			st_next.count = '0;
		end else if (dec.mod_tick) begin
			if (st_reg.count >= limit - ADCRC_COUNT_W'(1)) begin
				st_next.count = '0;
				st_next.done = 1'b1;
			end else begin
				st_next.count = st_reg.count + ADCRC_COUNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign dec.period_done = st_reg.done;

endmodule

// ===== dv/adcrc_chk.sv
// Port checker for the converter rate and current source control block
module adcrc_chk
	import adcrc_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Register port and mode
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire logic write_refused_out,
	input wire logic primary_active_in,
	input wire logic aux_active_in,
	// Timing and sources
	input wire logic [7:0] effective_rate_out,
	input wire logic mod_tick_out,
	input wire logic result_ready_out,
	input wire logic cal_busy_out,
	input wire logic coef_update_out,
	input wire logic burnout_enable_out,
	input wire logic aux_current_correction_out,
	input wire logic primary_current_correction_out,
	input wire logic exc1_source_one_out,
	input wire logic exc1_source_two_out,
	input wire logic exc2_source_one_out,
	input wire logic exc2_source_two_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Properties
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	logic busy;
	logic dec_wr;
	assign busy = primary_active_in | aux_active_in;
	assign dec_wr = sfr_wr_in && sfr_addr_in == ADCRC_DECIMATION_ADDR_DEF;
	// Last rate in force outside calibration
	logic [7:0] last_rate;
	always_ff @(posedge clk_in) begin
		if (!cal_busy_out) last_rate <= effective_rate_out;
	end
	rate_restore_a: assert property ($fell(cal_busy_out) |-> effective_rate_out == last_rate)
		else $error("programmed rate not restored");
	coef_after_cal_a: assert property (coef_update_out |-> !cal_busy_out && $past(cal_busy_out))
		else $error("coefficient update outside calibration");
	refuse_flag_a: assert property (dec_wr && busy |=> write_refused_out) else $error("rate write not refused");
	refuse_keep_a: assert property (dec_wr && busy && !cal_busy_out |=> cal_busy_out
		|| effective_rate_out == $past(effective_rate_out)) else $error("refused write changed rate");
	rate_write_a: assert property ((!busy)[*2] ##0 dec_wr |=> !write_refused_out
		&& effective_rate_out == $past(sfr_wdata_in)) else $error("idle rate write lost");
	cal_rate_a: assert property (cal_busy_out |-> effective_rate_out == ADCRC_DECIMATION_CAL)
		else $error("calibration not at full rate");
	rate_read_a: assert property (sfr_rd_in && !sfr_wr_in && sfr_addr_in == ADCRC_DECIMATION_ADDR_DEF
		|=> sfr_rdata_out == $past(effective_rate_out)) else $error("rate readback wrong");
	field_read_a: assert property (sfr_rd_in && !sfr_wr_in && sfr_addr_in == ADCRC_CURRENT_SOURCE_ADDR
		|=> sfr_rdata_out[7:4] == {1'b0, burnout_enable_out, aux_current_correction_out,
		primary_current_correction_out} && sfr_rdata_out[1] == (exc1_source_two_out | exc2_source_two_out)
		&& sfr_rdata_out[0] == (exc1_source_one_out | exc2_source_one_out)) else $error("source fields wrong");
	one_route_a: assert property (!(exc1_source_one_out && exc2_source_one_out)
		&& !(exc1_source_two_out && exc2_source_two_out)) else $error("source on two outputs");
	unmapped_a: assert property (sfr_rd_in && sfr_addr_in != ADCRC_CURRENT_SOURCE_ADDR
		&& sfr_addr_in != ADCRC_DECIMATION_ADDR_DEF |=> sfr_rdata_out == ADCRC_READ_ZERO)
		else $error("unmapped read not zero");
	tick_gap_a: assert property (mod_tick_out |=> !mod_tick_out [*8]) else $error("ticks too close");
	idle_quiet_a: assert property ((!busy)[*3] |-> !result_ready_out && !coef_update_out)
		else $error("result while idle");
	cover property (write_refused_out);
	cover property (cal_busy_out);
	cover property (result_ready_out);
endmodule

// ===== dv/tb.sv
// Self-checking bench for the converter rate and current source control block
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import adcrc_pkg::*;
	// ==========================================================
	// Signals
	logic clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic [7:0] sfr_addr_in = 8'h00;
	logic [7:0] sfr_wdata_in = 8'h00;
	logic sfr_wr_in = 1'b0;
	logic sfr_rd_in = 1'b0;
	logic primary_active_in = 1'b0;
	logic aux_active_in = 1'b0;
	logic [2:0] converter_mode_select_in = 3'h0;
	logic [7:0] sfr_rdata_out, effective_rate_out, v;
	logic write_refused_out, mod_tick_out, result_ready_out, cal_busy_out, coef_update_out;
	logic burnout_enable_out, aux_current_correction_out, primary_current_correction_out;
	logic exc1_source_one_out, exc1_source_two_out, exc2_source_one_out, exc2_source_two_out;
	logic rd_d = 1'b0;
	logic [7:0] exp_q[$];
	int fail_count = 0, samples_checked = 0, cycles = 0, refused_cnt = 0, seed = 25116, ticks;
	int word_ticks = ADCRC_CHOP_DIV * ADCRC_SINC_DIV * int'(ADCRC_DECIMATION_MIN);
	always #25 clk_in = ~clk_in;
	// Faster modulator clock keeps legal rate values within the run budget
	adcrc_ctrl #(.MOD_CLK_HZ(2_000_000)) dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .sfr_addr_in(sfr_addr_in),
		.sfr_wr_in(sfr_wr_in),
		.sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
		.write_refused_out(write_refused_out), .primary_active_in(primary_active_in),
		.aux_active_in(aux_active_in), .converter_mode_select_in(converter_mode_select_in),
		.effective_rate_out(effective_rate_out), .mod_tick_out(mod_tick_out), .result_ready_out(result_ready_out),
		.cal_busy_out(cal_busy_out), .coef_update_out(coef_update_out), .burnout_enable_out(burnout_enable_out),
		.aux_current_correction_out(aux_current_correction_out),
		.primary_current_correction_out(primary_current_correction_out),
		.exc1_source_one_out(exc1_source_one_out), .exc1_source_two_out(exc1_source_two_out),
		.exc2_source_one_out(exc2_source_one_out), .exc2_source_two_out(exc2_source_two_out));
	// ==========================================================
	// Tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		sfr_addr_in <= a;
		sfr_wdata_in <= d;
		sfr_wr_in <= 1'b1;
		@(posedge clk_in);
		sfr_wr_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic sfr_read(input logic [7:0] a, input logic [7:0] e);
		sfr_addr_in <= a;
		sfr_rd_in <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk_in);
		sfr_rd_in <= 1'b0;
		@(posedge clk_in);
	endtask
	// ==========================================================
	// Read monitor and hang guard
	always @(posedge clk_in) begin
		rd_d <= sfr_rd_in;
		cycles <= cycles + 1;
		if (cycles == 70000) begin
			fail_count++;
			print_verdict();
		end
	end
	always @(negedge clk_in) begin
		if (write_refused_out === 1'b1) refused_cnt++;
		if (rd_d) check(sfr_rdata_out, exp_q.pop_front());
	end
	// ==========================================================
	// Scenarios
	initial begin
		repeat (12) @(posedge clk_in);
		arst_n_in <= 1'b1;
		@(posedge clk_in);
		check(effective_rate_out, ADCRC_DECIMATION_RESET);
		sfr_read(ADCRC_CURRENT_SOURCE_ADDR, 8'h00);
		sfr_read(ADCRC_DECIMATION_ADDR_DEF, 8'h45);
		sfr_write(8'h10, 8'hAA);
		sfr_read(8'h10, 8'h00);
		$display("reset test done");
		for (int i = 0; i < 16; i++) begin
			v = 8'($random(seed));
			v[3:0] = 4'(i);
			sfr_write(ADCRC_CURRENT_SOURCE_ADDR, v);
			sfr_read(ADCRC_CURRENT_SOURCE_ADDR, v & 8'h7F);
			@(negedge clk_in);
			check(8'({burnout_enable_out, aux_current_correction_out, primary_current_correction_out}),
				8'(v[6:4]));
			check(8'({exc1_source_one_out, exc2_source_one_out}), 8'({v[0] & ~v[2], v[0] & v[2]}));
			check(8'({exc1_source_two_out, exc2_source_two_out}), 8'({v[1] & v[3], v[1] & ~v[3]}));
			@(posedge clk_in);
		end
		$display("source test done");
		sfr_write(ADCRC_DECIMATION_ADDR_DEF, ADCRC_DECIMATION_MIN);
		sfr_read(ADCRC_DECIMATION_ADDR_DEF, ADCRC_DECIMATION_MIN);
		for (int k = 1; k < 4; k++) begin
			primary_active_in <= k[0];
			aux_active_in <= k[1];
			@(posedge clk_in);
			sfr_write(ADCRC_DECIMATION_ADDR_DEF, 8'h80);
			sfr_read(ADCRC_DECIMATION_ADDR_DEF, ADCRC_DECIMATION_MIN);
			primary_active_in <= 1'b0;
			aux_active_in <= 1'b0;
			repeat (3) @(posedge clk_in);
		end
		check(8'(refused_cnt), 8'h03);
		$display("refusal test done");
		primary_active_in <= 1'b1;
		for (int n = 0; n < 2; n++) begin
			ticks = 0;
			@(negedge clk_in);
			while (result_ready_out !== 1'b1 && ticks < 1000) begin
				if (mod_tick_out === 1'b1) ticks++;
				@(negedge clk_in);
			end
			// One tick of slack for where the counting edge falls
			check(8'(ticks >= (2 - n) * word_ticks - 1 && ticks <= (2 - n) * word_ticks + 1), 8'h01);
		end
		@(posedge clk_in);
		primary_active_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		$display("timing test done");
		for (int m = 4; m < 8; m++) begin
			converter_mode_select_in <= 3'(m);
			aux_active_in <= 1'b1;
			repeat (4) @(posedge clk_in);
			check(8'(cal_busy_out), 8'h01);
			check(effective_rate_out, ADCRC_DECIMATION_CAL);
			sfr_read(ADCRC_DECIMATION_ADDR_DEF, ADCRC_DECIMATION_CAL);
			aux_active_in <= 1'b0;
			converter_mode_select_in <= 3'h0;
			repeat (3) @(posedge clk_in);
			check(8'(cal_busy_out), 8'h00);
			sfr_read(ADCRC_DECIMATION_ADDR_DEF, ADCRC_DECIMATION_MIN);
		end
		$display("calibration test done");
		print_verdict();
	end
endmodule
bind adcrc_ctrl adcrc_chk chk (.clk_in(clk_in), .arst_n_in(arst_n_in), .sfr_addr_in(sfr_addr_in),
	.sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
	.write_refused_out(write_refused_out), .primary_active_in(primary_active_in), .aux_active_in(aux_active_in),
	.effective_rate_out(effective_rate_out), .mod_tick_out(mod_tick_out), .result_ready_out(result_ready_out),
	.cal_busy_out(cal_busy_out), .coef_update_out(coef_update_out), .burnout_enable_out(burnout_enable_out),
	.aux_current_correction_out(aux_current_correction_out),
	.primary_current_correction_out(primary_current_correction_out),
	.exc1_source_one_out(exc1_source_one_out), .exc1_source_two_out(exc1_source_two_out),
	.exc2_source_one_out(exc2_source_one_out), .exc2_source_two_out(exc2_source_two_out));
